// *** sct_map.vh ***
/*
  address map, reset values, field positions and timing tables of the
  single-cycle core timing block.
  assumes it is included by bare name into the core timing module only.
*/
`ifndef SCT_MAP_VH
`define SCT_MAP_VH

// ----------------------------------------
// special function register offsets
// ----------------------------------------
`define SCT_SPL_ADDR 8'h81
`define SCT_DPL_ADDR 8'h82
`define SCT_DPH_ADDR 8'h83
`define SCT_DPP_ADDR 8'h84
`define SCT_PWR_ADDR 8'h87
`define SCT_DPC_ADDR 8'ha7
`define SCT_CFG_ADDR 8'haf
`define SCT_SPH_ADDR 8'hb7

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCT_SPL_RST 8'h07
`define SCT_DPL_RST 8'h00
`define SCT_DPH_RST 8'h00
`define SCT_DPP_RST 8'h00
`define SCT_PWR_RST 8'h00
`define SCT_DPC_RST 8'h00
`define SCT_CFG_RST 8'h00
`define SCT_SPH_RST 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCT_PWR_ALE_OFF 4
`define SCT_CFG_EXT_SP 7

// ----------------------------------------
// opcodes with side effects
// ----------------------------------------
`define SCT_OP_PUSH 8'hc0
`define SCT_OP_POP 8'hd0
`define SCT_OP_LONG_CALL 8'h12
`define SCT_OP_RET 8'h22
`define SCT_OP_RETI 8'h32
`define SCT_OP_INCDP 8'ha3

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define SCT_XMEM_BASE 5'd4
`define SCT_IRQ_CALL 5'd3
`define SCT_ABS_BRANCH 4'h3
// one nibble per high opcode nibble, nibble 0 lowest
`define SCT_TBL_L0 64'h4422_2233_3333_3331
`define SCT_TBL_L2 64'h4422_2222_2222_4433
`define SCT_TBL_L3 64'h4411_1344_3333_1111
`define SCT_TBL_L4 64'h1121_4929_9222_2211
`define SCT_TBL_L5 64'h2242_4123_3222_2222
`define SCT_TBL_RN 64'h1131_4212_2111_1111
`define SCT_IND_CMP 4'hb
`define SCT_IND_CYC 4'h2
`define SCT_CMP_CYC 4'h4

`endif

// *** sct_core_timing.v ***
/*
  instruction timing sequencer of a single-cycle 8-bit core: cycle counts
  per opcode, address latch strobe, timer tick, stack and data pointer
  registers with their special function register port.
  assumes opcodes come from internal program memory, all inputs are
  synchronous to sys_clk_i, and sys_clk_i runs at twice the undivided
  core rate so that each core cycle has two halves.
*/
// Overview of operation
// - one machine cycle is one core clock; timers tick every core clock
// - single-cycle instruction: strobe high first half, low second half
// - multi-cycle instruction: strobe high only in first half of first cycle
// - code comes only from internal memory; no external fetch cycles
// - software programs wait states to suit external data memory speed; here they come from the external_wait_states_i input
// - external data transfer takes four core clocks plus one per wait state
// - add, add-carry, subtract: register one cycle, other operands two
// - data pointer increment: one byte, three cycles, carry into page byte
// - multiply and divide take nine cycles, one byte each
// - logic immediate to direct: three cycles; accumulator to direct: two
// - clear, complement, swap and rotates of accumulator take one cycle
// - code byte reads relative to pointer or counter take four cycles
// - loading data pointer with immediate takes three bytes, three cycles
// - direct-direct and immediate-direct moves three cycles; register-accumulator one
// - push and pop of a direct byte take two bytes and two cycles
// - calls and pushes pre-increment stack pointer; pops and returns post-decrement
// - accumulator exchange with indirect memory, nibble too, takes two cycles
// - carry clear, set, complement one cycle; direct bit operations two cycles
// - short, absolute and carry or accumulator conditional jumps take three cycles
// - indirect jump relative to data pointer: one byte, three cycles
// - return and return from interrupt take four cycles
// - long jump, long call and bit test branches take three cycles
// - interrupt-inserted long call takes three cycles
// - compare-branch and direct decrement-branch four cycles; register form three
// - divider setting zero runs the core at full rate
`timescale 1ns/1ps
`include "sct_map.vh"

module sct_core_timing #(
  parameter WAIT_W = 3,
  parameter DIV_W = 3
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [DIV_W-1:0] clk_div_i,
  input wire [WAIT_W-1:0] external_wait_states_i,
  input wire [7:0] opcode_i,
  input wire opcode_valid_i,
  input wire irq_vector_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output wire opcode_ready_o,
  output wire irq_ack_o,
  output wire ale_o,
  output wire psen_n_o,
  output wire timer_tick_o,
  output wire [4:0] instr_cycles_o,
  output wire busy_o,
  output wire xmem_cycle_o,
  output wire [10:0] stack_addr_o,
  output wire [7:0] sfr_rdata_o
);

  // ----------------------------------------
  // core clock enable
  // ----------------------------------------
  reg [7:0] div_cnt_reg;
  reg phase_reg;
  wire [7:0] div_limit;
  wire half_tick;
  wire core_edge;

  // setting zero gives a half tick on every sys clock, the full rate
  assign div_limit = (8'h01 << clk_div_i) - 8'h01;
  // at or above the limit, so a smaller setting written mid-count cannot stall a full wrap
  assign half_tick = (div_cnt_reg >= div_limit);
  assign core_edge = half_tick & phase_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
    end else begin
      if (half_tick) begin
        div_cnt_reg <= 8'h00;
        phase_reg <= ~phase_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  // one machine cycle per core clock, so timers count every core edge
  assign timer_tick_o = core_edge;

  // ----------------------------------------
  // cycle count decode
  // ----------------------------------------
  function [3:0] nib;
    input [63:0] tbl;
    input [3:0] idx;
    begin
      nib = tbl[{idx, 2'b00} +: 4];
    end
  endfunction

  reg [3:0] base_cyc;
  reg [4:0] dec_cyc;
  wire [3:0] op_hi;
  wire [3:0] op_lo;
  wire is_xmem;

  assign op_hi = opcode_i[7:4];
  assign op_lo = opcode_i[3:0];
  assign is_xmem = (op_hi[3:1] == 3'b111) & ((op_lo == 4'h0) | (op_lo[3:1] == 3'b001));

  always @* begin
    case (op_lo)
      4'h0: base_cyc = nib(`SCT_TBL_L0, op_hi);
      4'h1: base_cyc = `SCT_ABS_BRANCH;
      4'h2: base_cyc = nib(`SCT_TBL_L2, op_hi);
      4'h3: base_cyc = nib(`SCT_TBL_L3, op_hi);
      4'h4: base_cyc = nib(`SCT_TBL_L4, op_hi);
      4'h5: base_cyc = nib(`SCT_TBL_L5, op_hi);
      4'h6, 4'h7: begin
        // indirect forms, exchange and nibble exchange included
        base_cyc = (op_hi == `SCT_IND_CMP) ? `SCT_CMP_CYC : `SCT_IND_CYC;
      end
      default: base_cyc = nib(`SCT_TBL_RN, op_hi);
    endcase
  end

  always @* begin
    if (is_xmem) begin
      // slow external memory is served by the stretch given on external_wait_states_i
      dec_cyc = `SCT_XMEM_BASE + {{(5-WAIT_W){1'b0}}, external_wait_states_i};
    end else begin
      dec_cyc = {1'b0, base_cyc};
    end
  end

  // ----------------------------------------
  // issue sequencer
  // ----------------------------------------
  reg [4:0] left_reg;
  reg first_reg;
  reg [4:0] cyc_reg;
  reg xmem_reg;
  wire slot_free;
  wire take_irq;
  wire take_op;
  wire [4:0] new_cyc;

  // the last cycle of an instruction is also the issue slot of the next
  assign slot_free = core_edge & (left_reg <= 5'd1);
  assign take_irq = slot_free & irq_vector_i;
  assign take_op = slot_free & ~irq_vector_i & opcode_valid_i;
  assign opcode_ready_o = slot_free & ~irq_vector_i;
  assign irq_ack_o = take_irq;
  assign new_cyc = take_irq ? `SCT_IRQ_CALL : dec_cyc;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_reg <= 5'd0;
      first_reg <= 1'b0;
      cyc_reg <= 5'd0;
      xmem_reg <= 1'b0;
    end else if (core_edge) begin
      if (take_irq | take_op) begin
        left_reg <= new_cyc;
        first_reg <= 1'b1;
        cyc_reg <= new_cyc;
        xmem_reg <= take_op & is_xmem;
      end else begin
        left_reg <= (left_reg == 5'd0) ? 5'd0 : left_reg - 5'd1;
        first_reg <= 1'b0;
        if (left_reg <= 5'd1) begin
          xmem_reg <= 1'b0;
        end
      end
    end
  end

  assign busy_o = (left_reg != 5'd0);
  assign instr_cycles_o = cyc_reg;
  assign xmem_cycle_o = xmem_reg;

  // ----------------------------------------
  // address latch strobe and program store enable
  // ----------------------------------------
  reg [7:0] pwr_reg;

  // high in the first half of the first cycle only; back-to-back
  // single-cycle instructions therefore toggle it at core rate
  assign ale_o = first_reg & ~phase_reg & ~pwr_reg[`SCT_PWR_ALE_OFF];

  // there is no external code space, so the fetch strobe never asserts
  assign psen_n_o = 1'b1;

  // ----------------------------------------
  // stack pointer and data pointer
  // ----------------------------------------
  reg [10:0] sp_reg;
  reg [10:0] sp_next;
  reg [10:0] sa_reg;
  reg [10:0] sa_next;
  reg [23:0] dp_reg;
  reg [23:0] dp_next;
  reg [7:0] dpc_reg;
  reg [7:0] cfg_reg;
  wire ext_sp;
  wire is_push;
  wire is_pop;
  wire is_call;
  wire is_ret;
  localparam [15:0] SP_RST_VAL = {`SCT_SPH_RST, `SCT_SPL_RST};

  assign ext_sp = cfg_reg[`SCT_CFG_EXT_SP];
  assign is_push = take_op & (opcode_i == `SCT_OP_PUSH);
  assign is_pop = take_op & (opcode_i == `SCT_OP_POP);
  assign is_call = take_irq | (take_op & ((opcode_i == `SCT_OP_LONG_CALL) |
                   ((op_lo == 4'h1) & op_hi[0])));
  assign is_ret = take_op & ((opcode_i == `SCT_OP_RET) | (opcode_i == `SCT_OP_RETI));

  // without the extension the pointer wraps inside the 256-byte page
  function [10:0] sp_add;
    input [10:0] sp;
    input [10:0] d;
    input ext;
    reg [10:0] s;
    begin
      s = sp + d;
      sp_add = ext ? s : {3'b000, s[7:0]};
    end
  endfunction

  always @* begin
    sp_next = sp_reg;
    sa_next = sa_reg;
    dp_next = dp_reg;
    if (sfr_wr_i) begin
      if (sfr_addr_i == `SCT_SPL_ADDR) begin
        sp_next[7:0] = sfr_wdata_i;
      end
      if ((sfr_addr_i == `SCT_SPH_ADDR) & ext_sp) begin
        sp_next[10:8] = sfr_wdata_i[2:0];
      end
      if (sfr_addr_i == `SCT_DPL_ADDR) begin
        dp_next[7:0] = sfr_wdata_i;
      end
      if (sfr_addr_i == `SCT_DPH_ADDR) begin
        dp_next[15:8] = sfr_wdata_i;
      end
      if (sfr_addr_i == `SCT_DPP_ADDR) begin
        dp_next[23:16] = sfr_wdata_i;
      end
    end
    // an instruction issued in the same cycle wins over a port write
    if (is_push) begin
      sp_next = sp_add(sp_reg, 11'd1, ext_sp);
      sa_next = sp_next;
    end else if (is_call) begin
      sp_next = sp_add(sp_reg, 11'd2, ext_sp);
      sa_next = sp_add(sp_reg, 11'd1, ext_sp);
    end else if (is_pop) begin
      sa_next = sp_reg;
      sp_next = sp_add(sp_reg, 11'h7ff, ext_sp);
    end else if (is_ret) begin
      sa_next = sp_reg;
      sp_next = sp_add(sp_reg, 11'h7fe, ext_sp);
    end
    if (take_op & (opcode_i == `SCT_OP_INCDP)) begin
      dp_next = dp_reg + 24'h000001;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;

  always @* begin
    case (sfr_addr_i)
      `SCT_SPL_ADDR: rdata_next = sp_reg[7:0];
      `SCT_DPL_ADDR: rdata_next = dp_reg[7:0];
      `SCT_DPH_ADDR: rdata_next = dp_reg[15:8];
      `SCT_DPP_ADDR: rdata_next = dp_reg[23:16];
      `SCT_PWR_ADDR: rdata_next = pwr_reg;
      `SCT_DPC_ADDR: rdata_next = dpc_reg;
      `SCT_CFG_ADDR: rdata_next = cfg_reg;
      `SCT_SPH_ADDR: rdata_next = ext_sp ? {5'b00000, sp_reg[10:8]} : 8'h00;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_reg <= SP_RST_VAL[10:0];
      sa_reg <= 11'h000;
      dp_reg <= {`SCT_DPP_RST, `SCT_DPH_RST, `SCT_DPL_RST};
      pwr_reg <= `SCT_PWR_RST;
      dpc_reg <= `SCT_DPC_RST;
      cfg_reg <= `SCT_CFG_RST;
      rdata_reg <= 8'h00;
    end else begin
      sp_reg <= sp_next;
      sa_reg <= sa_next;
      dp_reg <= dp_next;
      if (sfr_wr_i & (sfr_addr_i == `SCT_PWR_ADDR)) begin
        pwr_reg <= sfr_wdata_i;
      end
      if (sfr_wr_i & (sfr_addr_i == `SCT_DPC_ADDR)) begin
        dpc_reg <= sfr_wdata_i;
      end
      if (sfr_wr_i & (sfr_addr_i == `SCT_CFG_ADDR)) begin
        cfg_reg <= sfr_wdata_i;
      end
      if (sfr_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign stack_addr_o = sa_reg;
  assign sfr_rdata_o = rdata_reg;

endmodule

// *** sct_core_timing_chk.sv ***
/* port assertions for the core timing block.
   assumes a bind into the core timing module and divider setting 0. */
`timescale 1ns/1ps
module sct_core_timing_chk #(
  parameter WAIT_W = 3,
  parameter DIV_W = 3
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [DIV_W-1:0] clk_div_i,
  input wire logic [WAIT_W-1:0] external_wait_states_i,
  input wire logic [7:0] opcode_i,
  input wire logic opcode_valid_i,
  input wire logic irq_vector_i,
  input wire logic opcode_ready_o,
  input wire logic irq_ack_o,
  input wire logic ale_o,
  input wire logic psen_n_o,
  input wire logic timer_tick_o,
  input wire logic [4:0] instr_cycles_o,
  input wire logic xmem_cycle_o,
  input wire logic [10:0] stack_addr_o
);
  // --------------------------------
  // helper state
  // --------------------------------
  logic [WAIT_W-1:0] wl;
  logic [5:0] xcnt;
  wire take = opcode_ready_o && opcode_valid_i && !irq_vector_i;
  // only external moves latch the setting, so a later change is not seen early
  wire xop = opcode_i[7:5] == 3'h7 && opcode_i[3:2] == 2'h0 && opcode_i[1:0] != 2'h1;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wl <= '0;
      xcnt <= 6'h00;
    end else begin
      if (take && xop)
        wl <= external_wait_states_i;
      xcnt <= xmem_cycle_o ? xcnt + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take(logic [7:0] op);
    take && opcode_i == op;
  endsequence
  // --------------------------------
  // properties
  // --------------------------------
  AST_NO_CODE_FETCH: assert property (psen_n_o)
    else $error("code fetch strobe asserted");
  AST_TICK_RATE: assert property (
    timer_tick_o && clk_div_i == '0 |=> !timer_tick_o ##1 timer_tick_o)
    else $error("timer tick not every core clock");
  AST_NOP_STROBE: assert property (
    s_take(8'h00) |=> ale_o ##1 (!ale_o && opcode_ready_o))
    else $error("single cycle strobe or issue wrong");
  AST_MUL_STROBE: assert property (s_take(8'ha4) |=> ale_o && !opcode_ready_o
    ##1 (!ale_o && !opcode_ready_o)[*8] ##1 (!ale_o && !opcode_ready_o)[*8]
    ##1 opcode_ready_o)
    else $error("multiply strobe or length wrong");
  AST_XMEM_LEN: assert property (
    $fell(xmem_cycle_o) |-> xcnt == {wl, 1'b0} + 6'h08)
    else $error("external move length wrong");
  AST_INCDP_LEN: assert property (s_take(8'ha3) |=> instr_cycles_o == 5'h03
    ##4 !opcode_ready_o ##1 opcode_ready_o)
    else $error("pointer increment length wrong");
  AST_IRQ_CALL: assert property (irq_ack_o |-> !opcode_ready_o
    ##1 (instr_cycles_o == 5'h03)[*5] ##1 (opcode_ready_o || irq_ack_o))
    else $error("vector call length wrong");
  AST_PUSH_POP: assert property (
    s_take(8'hc0) ##4 s_take(8'hd0) |=> $stable(stack_addr_o))
    else $error("pop address differs from push");
  AST_CALL_RET: assert property (
    s_take(8'h12) ##6 s_take(8'h22) |=> stack_addr_o == $past(stack_addr_o) + 11'h001)
    else $error("return address wrong after call");
endmodule

// *** sct_xmem_model.sv ***
/* external data memory partner: asks for the wait setting it needs and
   flags any transfer shorter than it can serve.
   assumes divider setting 0, two sys clocks per core clock. */
`timescale 1ns/1ps
module sct_xmem_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic xmem_cycle_i,
  input wire logic [2:0] need_i,
  output logic [2:0] wait_o,
  output logic short_o
);
  logic [5:0] len;
  assign wait_o = need_i;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      len <= 6'h00;
      short_o <= 1'b0;
    end else if (xmem_cycle_i) begin
      len <= len + 6'h01;
    end else begin
      if (len != 6'h00 && len < {need_i, 1'b0} + 6'h08)
        short_o <= 1'b1;
      len <= 6'h00;
    end
  end
endmodule

// *** sct_core_timing_tb_top.sv ***
/* self-checking bench of the core timing block.
   assumes the checker and memory model files compile first. */
`timescale 1ns/1ps
module sct_core_timing_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] clk_div_i = 3'h0;
  logic [2:0] need = 3'h0;
  logic [7:0] opcode_i = 8'h00;
  logic opcode_valid_i = 1'b0;
  logic irq_vector_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  wire opcode_ready_o, irq_ack_o, ale_o, xmem_cycle_o, short, busy;
  wire [2:0] wait_st;
  wire [4:0] instr_cycles_o;
  wire [10:0] stack_addr_o;
  wire [7:0] sfr_rdata_o;
  logic [10:0] sa;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ale_exp = 1;
  always #4 sys_clk_i = ~sys_clk_i;
  sct_core_timing dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_div_i(clk_div_i),
    .external_wait_states_i(wait_st), .opcode_i(opcode_i), .opcode_valid_i(opcode_valid_i),
    .irq_vector_i(irq_vector_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .opcode_ready_o(opcode_ready_o),
    .irq_ack_o(irq_ack_o), .ale_o(ale_o), .psen_n_o(), .timer_tick_o(),
    .instr_cycles_o(instr_cycles_o), .busy_o(busy), .xmem_cycle_o(xmem_cycle_o),
    .stack_addr_o(stack_addr_o), .sfr_rdata_o(sfr_rdata_o));
  sct_xmem_model mem (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .xmem_cycle_i(xmem_cycle_o), .need_i(need), .wait_o(wait_st), .short_o(short));
  // --------------------------------
  // shared tasks
  // --------------------------------
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one issue; length is judged both by the count port and by the gap to the next issue slot
  task automatic run(input logic [7:0] op, input logic [4:0] n);
    int k;
    int a;
    k = 0;
    opcode_i = op;
    opcode_valid_i = !irq_vector_i;
    #1;
    while (!(opcode_ready_o || irq_ack_o) && k < 100) begin
      @(negedge sys_clk_i);
      k++;
    end
    @(negedge sys_clk_i);
    opcode_valid_i = 1'b0;
    irq_vector_i = 1'b0;
    sa = stack_addr_o;
    chk(instr_cycles_o, n, "cycles");
    chk(busy, 1'b1, "busy");
    a = ale_o;
    k = 1;
    while (!opcode_ready_o && k < 40) begin
      @(negedge sys_clk_i);
      a += ale_o;
      k++;
    end
    chk(k, (2 * n) << clk_div_i, "gap");
    chk(a, ale_exp << clk_div_i, "strobes");
  endtask
  task automatic sfr(input logic w, input logic [7:0] ad, input logic [7:0] d);
    sfr_addr_i = ad;
    sfr_wdata_i = d;
    sfr_wr_i = w;
    sfr_rd_i = !w;
    @(negedge sys_clk_i);
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    @(negedge sys_clk_i);
    if (!w)
      chk(sfr_rdata_o, d, "sfr");
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs();
    logic [7:0] ad[8] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h87, 8'ha7, 8'haf, 8'hb7};
    chk(busy, 1'b0, "idle");
    for (int i = 0; i < 8; i++)
      sfr(1'b0, ad[i], i == 0 ? 8'h07 : 8'h00);
    sfr(1'b0, 8'h85, 8'h00);
    sfr(1'b1, 8'hb7, 8'h05);
    sfr(1'b0, 8'hb7, 8'h00);
    sfr(1'b1, 8'haf, 8'h80);
    sfr(1'b1, 8'hb7, 8'h05);
    sfr(1'b0, 8'hb7, 8'h05);
  endtask
  task automatic t_stack();
    sfr(1'b1, 8'h81, 8'hff);
    run(8'hc0, 5'h02);
    chk(sa, 11'h600, "push");
    run(8'hd0, 5'h02);
    chk(sa, 11'h600, "pop");
    run(8'h12, 5'h03);
    chk(sa, 11'h600, "call");
    run(8'h22, 5'h04);
    chk(sa, 11'h601, "ret");
    sfr(1'b0, 8'h81, 8'hff);
  endtask
  task automatic t_data_pointer();
    sfr(1'b1, 8'h82, 8'hff);
    sfr(1'b1, 8'h83, 8'hff);
    sfr(1'b1, 8'h84, 8'h12);
    run(8'ha3, 5'h03);
    sfr(1'b0, 8'h83, 8'h00);
    sfr(1'b0, 8'h84, 8'h13);
    run(8'h90, 5'h03);
  endtask
  task automatic t_ops();
    run(8'h28, 5'h01);
    run(8'h94, 5'h02);
    run(8'ha4, 5'h09);
    run(8'h84, 5'h09);
    run(8'h53, 5'h03);
    run(8'h62, 5'h02);
    run(8'hc4, 5'h01);
    run(8'h33, 5'h01);
    run(8'h93, 5'h04);
    run(8'h85, 5'h03);
    run(8'hd6, 5'h02);
    run(8'hb3, 5'h01);
    run(8'h82, 5'h02);
    run(8'h60, 5'h03);
    run(8'h73, 5'h03);
    run(8'h20, 5'h03);
    run(8'hb4, 5'h04);
    run(8'hd8, 5'h03);
    // strobe switched off in the power control register
    sfr(1'b1, 8'h87, 8'h10);
    ale_exp = 0;
    run(8'h28, 5'h01);
    ale_exp = 1;
    sfr(1'b1, 8'h87, 8'h00);
  endtask
  task automatic t_xmem();
    for (int w = 0; w < 8; w++) begin
      need = w[2:0];
      run(w[0] ? 8'hf0 : 8'he0, 5'h04 + w[4:0]);
      run(8'h00, 5'h01);
    end
    chk(short, 1'b0, "slow");
  endtask
  task automatic t_irq();
    // let the slot after the last single-cycle op go by first
    @(negedge sys_clk_i);
    irq_vector_i = 1'b1;
    run(8'h00, 5'h03);
    @(negedge sys_clk_i);
    chk(busy, 1'b0, "idle");
  endtask
  // divider changed only under reset, so no running property sees a half-changed rate
  task automatic t_div();
    rst_n_i = 1'b0;
    clk_div_i = 3'h1;
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    chk(busy, 1'b0, "reset");
    sfr(1'b0, 8'h81, 8'h07);
    run(8'h28, 5'h01);
    run(8'h94, 5'h02);
  endtask
  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    t_regs();
    t_stack();
    t_data_pointer();
    t_ops();
    t_xmem();
    t_irq();
    t_div();
    end_sim();
  end
endmodule
bind sct_core_timing sct_core_timing_chk #(.WAIT_W(WAIT_W), .DIV_W(DIV_W)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_div_i(clk_div_i),
  .external_wait_states_i(external_wait_states_i), .opcode_i(opcode_i),
  .opcode_valid_i(opcode_valid_i), .irq_vector_i(irq_vector_i),
  .opcode_ready_o(opcode_ready_o), .irq_ack_o(irq_ack_o), .ale_o(ale_o),
  .psen_n_o(psen_n_o), .timer_tick_o(timer_tick_o), .instr_cycles_o(instr_cycles_o),
  .xmem_cycle_o(xmem_cycle_o), .stack_addr_o(stack_addr_o));
